// File: hdl/cec_error_supervisor.sv
// Error supervisor of an electronic cam controller: raises numbered errors,
// blanks the switching outputs, and handles acknowledgement side effects.
// Assumes all inputs synchronous to clk_i; ack_i is a one-cycle pulse.
`timescale 1ns/1ns
module cec_error_supervisor
    import cec_pkg::*;
#(
    parameter int unsigned NOUT = 16,
    parameter int unsigned GW = 12,
    parameter logic [31:0] PLL_LIMIT = 32'h0010_0000
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [GW-1:0] gray_i,
    input wire logic gray_valid_i,
    input wire logic [GW:0] resolution_i,
    input wire logic cfg_bad_i,
    input wire logic csum_done_i,
    input wire logic csum_ok_i,
    input wire logic monitor_en_i,
    input wire logic enc_fault_i,
    input wire logic ssi_timeout_i,
    input wire logic ssi_gray_bad_i,
    input wire cec_serial_t serial_i,
    input wire cec_net_t net_i,
    input wire logic fieldbus_fitted_i,
    input wire logic fieldbus_conn_i,
    input wire logic [15:0] count_range_i,
    input wire logic [15:0] shaft_speed_i,
    input wire logic blank_save_i,
    input wire logic record_complete_i,
    input wire logic [NOUT-1:0] overload_i,
    input wire logic [NOUT-1:0] cam_i,
    input wire logic ack_i,
    output logic [NOUT-1:0] outputs_o,
    output cec_code_t code_o,
    output logic [NSRC-1:0] pending_o,
    output logic store_reset_o,
    output logic save_reject_o
);

    localparam logic [15:0] BLANK_CYC = 16'(OVL_BLANK_CYC);

    generate
        if (NOUT < 1 || GW < 2 || OVL_BLANK_CYC > 65535) begin : g_bad
            $error("cec_error_supervisor: unsupported parameter values");
        end
    endgenerate

    logic gray_illegal;
    logic [NSRC-1:0] ev;
    logic res_pow2;
    logic [31:0] pll_load;
    logic serious;
    logic ack_hit;
    logic [NSRC-1:0] pend_r, pend_nxt;
    cec_code_t code_r, code_nxt;
    cec_src_t src_r, src_nxt;
    logic [NOUT-1:0] off_r, off_nxt;
    logic [NOUT-1:0] out_r, out_nxt;
    logic [15:0] blank_r, blank_nxt;
    logic csum_seen_r, csum_seen_nxt;
    logic store_r, store_nxt;
    logic reject_r, reject_nxt;

    cec_gray_check #(.W(GW)) u_gray (
        .gray_i(gray_i),
        .res_i(resolution_i),
        .bin_o(),
        .illegal_o(gray_illegal)
    );

    // Error events
    always_comb begin
        res_pow2 = (resolution_i != '0) && ((resolution_i & (resolution_i - 1'b1)) == '0);
        pll_load = 32'(count_range_i) * 32'(shaft_speed_i);
        ev = '0;
        ev[E_GRAY] = gray_valid_i && gray_illegal;
        ev[E_CSUM] = csum_done_i && !csum_seen_r && !csum_ok_i;
        ev[E_CFG] = cfg_bad_i || !res_pow2;
        ev[E_ENC] = monitor_en_i && enc_fault_i;
        ev[E_SSITO] = ssi_timeout_i;
        ev[E_SSIGR] = ssi_gray_bad_i;
        ev[E_OVL] = |overload_i;
        ev[E_NTX] = net_i.tx_dup;
        ev[E_NRX] = net_i.rx_dup;
        ev[E_NID] = net_i.node_clash || net_i.line_fault;
        ev[E_FB] = fieldbus_fitted_i && !fieldbus_conn_i;
        ev[E_RXOV] = serial_i.rx_char && serial_i.rx_full;
        ev[E_TXOV] = serial_i.tx_push && serial_i.tx_full;
        ev[E_BLANK] = blank_save_i && !record_complete_i;
        ev[E_PLL] = pll_load > PLL_LIMIT;
    end

    assign serious = |(pend_r & SERIOUS_MASK);
    assign ack_hit = ack_i && code_r.valid;

    // Pending flags, code field and side effects
    always_comb begin
        pend_nxt = pend_r;
        code_nxt = code_r;
        src_nxt = src_r;
        off_nxt = off_r | overload_i;
        blank_nxt = (blank_r != '0) ? blank_r - 1'b1 : blank_r;
        csum_seen_nxt = csum_seen_r | csum_done_i;
        store_nxt = 1'b0;
        reject_nxt = ev[E_BLANK];
        if (ack_hit) begin
            pend_nxt[src_r] = 1'b0;
            code_nxt.valid = 1'b0;
            code_nxt.num = CODE_NONE;
            store_nxt = (src_r == cec_src_t'(E_CSUM));
            if (src_r == cec_src_t'(E_OVL)) begin
                off_nxt = overload_i;
                blank_nxt = BLANK_CYC;
            end
        end
        // New events win over the acknowledge
        pend_nxt = pend_nxt | ev;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (ev[i]) begin
                code_nxt.valid = 1'b1;
                code_nxt.num = ERR_CODE[i];
                src_nxt = cec_src_t'(i);
            end
        end
    end

    // Switching outputs
    always_comb begin
        out_nxt = cam_i & ~off_r;
        if (serious || blank_r != '0) begin
            out_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_r <= '0;
            code_r <= '0;
            src_r <= '0;
            off_r <= '0;
            out_r <= '0;
            blank_r <= '0;
            csum_seen_r <= 1'b0;
            store_r <= 1'b0;
            reject_r <= 1'b0;
        end else if (en_i) begin
            pend_r <= pend_nxt;
            code_r <= code_nxt;
            src_r <= src_nxt;
            off_r <= off_nxt;
            out_r <= out_nxt;
            blank_r <= blank_nxt;
            csum_seen_r <= csum_seen_nxt;
            store_r <= store_nxt;
            reject_r <= reject_nxt;
        end
    end

    assign outputs_o = out_r;
    assign code_o = code_r;
    assign pending_o = pend_r;
    assign store_reset_o = store_r;
    assign save_reject_o = reject_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence ovl_ack_s;
        en_i && ack_hit && src_r == cec_src_t'(E_OVL);
    endsequence

    sequence blank_start_s;
        blank_r == BLANK_CYC;
    endsequence

    gray_flag_a: assert property (en_i && gray_valid_i && gray_illegal |=> pend_r[E_GRAY])
        else $error("illegal gray code not flagged");
    csum_flag_a: assert property (en_i && csum_done_i && !csum_ok_i && !csum_seen_r
        && !ev[E_GRAY] |=> code_r.valid && code_r.num == 8'h65)
        else $error("checksum failure not reported as 101");
    store_reset_a: assert property (en_i && ack_hit && src_r == cec_src_t'(E_CSUM)
        |=> store_reset_o ##1 (!store_reset_o || !$past(en_i)))
        else $error("store reset pulse missing after checksum ack");
    serious_off_a: assert property (en_i && serious |=> outputs_o == '0)
        else $error("outputs driven during serious error");
    ovl_blank_a: assert property (ovl_ack_s |=> blank_start_s ##0 (!en_i or
        (1'b1 ##1 outputs_o == '0)))
        else $error("overload ack did not blank outputs");
    enc_mon_a: assert property (en_i && !monitor_en_i && !pend_r[E_ENC]
        |=> !pend_r[E_ENC])
        else $error("encoder fault raised with monitoring off");
    cfg_res_a: assert property (en_i && resolution_i == (GW+1)'(8'h7f) |=> pend_r[E_CFG])
        else $error("non power of two resolution not flagged");
    rx_ovf_a: assert property (en_i && serial_i.rx_char && serial_i.rx_full
        |=> pend_r[E_RXOV])
        else $error("receive overflow not flagged");
    tx_ovf_a: assert property (en_i && serial_i.tx_push && serial_i.tx_full
        |=> pend_r[E_TXOV])
        else $error("transmit overflow not flagged");
    net_dup_a: assert property (en_i && net_i.rx_dup && !net_i.tx_dup
        && ev[E_NRX-1:0] == '0 |=> code_r.num == 8'h29)
        else $error("receive duplicate not reported as 41");
    blank_rej_a: assert property (en_i && blank_save_i && !record_complete_i
        |=> save_reject_o && pend_r[E_BLANK])
        else $error("incomplete blank cam save not rejected");
    ovl_single_a: assert property (en_i && overload_i[0] && !serious && cam_i[NOUT-1]
        && !overload_i[NOUT-1] && !off_r[NOUT-1] && blank_r == '0 |=> en_i [*1]
        |=> outputs_o[0] == 1'b0)
        else $error("overloaded output not switched off");
    ack_clear_a: assert property (en_i && ack_hit && ev == '0 |=> !code_r.valid
        && code_r.num == CODE_NONE)
        else $error("code field not cleared by ack");

endmodule // cec_error_supervisor

// File: hdl/cec_pkg.sv
// Package for the cam controller error supervisor: codes, indices, timing, types.
// Assumes a single 100 MHz clock domain.
package cec_pkg;

    // Clock and overload blank pulse timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned OVL_BLANK_US = 10;
    localparam int unsigned OVL_BLANK_CYC = OVL_BLANK_US * CLK_MHZ;

    // Error source indices
    localparam int unsigned E_GRAY = 0;
    localparam int unsigned E_CSUM = 1;
    localparam int unsigned E_CFG = 2;
    localparam int unsigned E_ENC = 3;
    localparam int unsigned E_SSITO = 4;
    localparam int unsigned E_SSIGR = 5;
    localparam int unsigned E_OVL = 6;
    localparam int unsigned E_NTX = 7;
    localparam int unsigned E_NRX = 8;
    localparam int unsigned E_NID = 9;
    localparam int unsigned E_FB = 10;
    localparam int unsigned E_RXOV = 11;
    localparam int unsigned E_TXOV = 12;
    localparam int unsigned E_BLANK = 13;
    localparam int unsigned E_PLL = 14;
    localparam int unsigned NSRC = 15;

    // Serious errors occupy the lowest indices
    localparam logic [NSRC-1:0] SERIOUS_MASK = 15'h003f;

    // Error numbers, indexed by source
    localparam logic [7:0] ERR_CODE [0:NSRC-1] = '{
        8'h64, 8'h65, 8'h68, 8'h69, 8'h6c, 8'h6f, 8'h1f, 8'h28,
        8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f
    };

    // Code field reset value
    localparam logic [7:0] CODE_NONE = 8'h00;

    typedef logic [3:0] cec_src_t;

    typedef struct packed {
        logic valid;
        logic [7:0] num;
    } cec_code_t;

    typedef struct packed {
        logic rx_char;
        logic rx_full;
        logic tx_push;
        logic tx_full;
    } cec_serial_t;

    typedef struct packed {
        logic tx_dup;
        logic rx_dup;
        logic node_clash;
        logic line_fault;
    } cec_net_t;

endpackage

// File: hdl/cec_gray_check.sv
// Gray to binary conversion and range check of the encoder position word.
// Assumes a clipped Gray code whose legal values lie below the resolution.
`timescale 1ns/1ns
module cec_gray_check
    import cec_pkg::*;
#(
    parameter int unsigned W = 12
) (
    input wire logic [W-1:0] gray_i,
    input wire logic [W:0] res_i,
    output logic [W-1:0] bin_o,
    output logic illegal_o
);

    genvar b;
    generate
        if (W < 2) begin : g_bad
            $error("cec_gray_check: W must be at least 2");
        end
        // Each binary bit is the xor of its own Gray bit and all higher Gray bits
        for (b = 0; b < W; b++) begin : g_bit
            assign bin_o[b] = ^gray_i[W-1:b];
        end
    endgenerate

    assign illegal_o = ({1'b0, bin_o} >= res_i);

endmodule // cec_gray_check

// File: dv/cec_enc_model.sv
// Absolute encoder model: turns a binary shaft position into its Gray word.
// Assumes the bench changes the position just after a clock edge.
`timescale 1ns/1ns
module cec_enc_model (
    input wire logic [11:0] pos_i,
    output logic [11:0] gray_o
);
    assign gray_o = pos_i ^ (pos_i >> 1);
endmodule // cec_enc_model

// File: dv/cec_error_supervisor_tb.sv
// Bench for the error supervisor: fires each error source, acknowledges it.
// Assumes the encoder model drives the Gray word; one 100 MHz clock.
`timescale 1ns/1ns
module cec_error_supervisor_tb;
    import cec_pkg::*;
    logic clk_i = 0;
    logic nrst_i = 0;
    logic ack_i = 0;
    logic cdone = 0;
    logic cok = 1;
    logic mon = 1;
    logic efault = 0;
    logic cfg = 0;
    logic sto = 0;
    logic sgb = 0;
    logic conn = 1;
    logic save = 0;
    logic cmpl = 1;
    logic en = 1;
    logic gvalid = 1;
    logic fitted = 1;
    logic [12:0] res = 13'h0800;
    logic [11:0] pos = 12'h100;
    logic [11:0] gray;
    logic [15:0] rng = 16'h0010;
    logic [15:0] spd = 16'h0200;
    logic [15:0] ovl = 16'h0000;
    logic [15:0] cam = 16'h00ff;
    cec_serial_t ser = '0;
    cec_net_t net = '0;
    logic [15:0] outputs_o;
    cec_code_t code_o;
    logic [NSRC-1:0] pending_o;
    logic store_reset_o;
    logic save_reject_o;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int ks [20] = '{1, 0, 2, 3, 16, 4, 5, 6, 7, 8, 9, 15, 10, 11, 12, 13, 14, 17, 18, 19};

    always #5 clk_i = ~clk_i;

    cec_enc_model enc (.pos_i(pos), .gray_o(gray));

    cec_error_supervisor dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .gray_i(gray), .gray_valid_i(gvalid),
        .resolution_i(res), .cfg_bad_i(cfg), .csum_done_i(cdone), .csum_ok_i(cok),
        .monitor_en_i(mon), .enc_fault_i(efault), .ssi_timeout_i(sto),
        .ssi_gray_bad_i(sgb), .serial_i(ser), .net_i(net), .fieldbus_fitted_i(fitted),
        .fieldbus_conn_i(conn), .count_range_i(rng), .shaft_speed_i(spd),
        .blank_save_i(save), .record_complete_i(cmpl), .overload_i(ovl), .cam_i(cam),
        .ack_i(ack_i), .outputs_o(outputs_o), .code_o(code_o), .pending_o(pending_o),
        .store_reset_o(store_reset_o), .save_reject_o(save_reject_o)
    );

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Raise or drop one error cause
    task automatic drive(int k, logic v);
        case (k)
            0, 18: pos <= v ? 12'h900 : 12'h100;
            1: cdone <= v;
            2: cfg <= v;
            3, 16: efault <= v;
            4: sto <= v;
            5: sgb <= v;
            6: ovl <= v ? 16'h0002 : 16'h0000;
            7: net.tx_dup <= v;
            8: net.rx_dup <= v;
            9: net.node_clash <= v;
            15: net.line_fault <= v;
            10, 19: conn <= !v;
            11: ser <= v ? 4'hc : 4'h0;
            12: ser <= v ? 4'h3 : 4'h0;
            13: save <= v;
            14: rng <= v ? 16'h1000 : 16'h0010;
            17: begin
                res <= v ? 13'h007f : 13'h0800;
                pos <= v ? 12'h010 : 12'h100;
            end
            default: ;
        endcase
        gvalid <= !(v && k == 18);
        fitted <= !(v && k == 19);
        cok <= !(v && k == 1);
        cmpl <= !(v && k == 13);
        mon <= (k != 16);
    endtask

    // One error source: raise, judge, acknowledge, judge recovery
    task automatic event_case(int k);
        int src;
        logic [15:0] exp_out;
        src = (k == 15) ? 9 : (k == 16) ? 3 : (k == 17) ? 2 : k;
        exp_out = SERIOUS_MASK[src] ? 16'h0 : cam & ~(16'(k == 6) << 1);
        @(posedge clk_i) drive(k, 1);
        @(posedge clk_i) drive(k, 0);
        @(negedge clk_i);
        check("reject", save_reject_o, k == 13);
        if (k == 16 || k >= 18) begin
            check("code_valid", code_o.valid, 0);
            return;
        end
        check("code", code_o.num, ERR_CODE[src]);
        check("pending", pending_o[src], 1);
        // Output blanking follows the pending flags one cycle later
        @(negedge clk_i);
        check("outputs", outputs_o, exp_out);
        @(posedge clk_i) ack_i <= 1;
        @(posedge clk_i) ack_i <= 0;
        @(negedge clk_i);
        check("cleared", code_o.valid, 0);
        check("store_reset", store_reset_o, k == 1);
        if (k == 6) begin
            @(negedge clk_i);
            check("blank_first", outputs_o, 16'h0);
            repeat (OVL_BLANK_CYC - 1) @(negedge clk_i);
            check("blank_last", outputs_o, 16'h0);
        end
        @(negedge clk_i);
        check("resume", outputs_o, cam);
    endtask

    // Clock enable low: an error arriving while frozen is not taken until enable returns, then it is
    task automatic freeze_case();
        @(posedge clk_i) begin
            en <= 0;
            cfg <= 1;
        end
        @(posedge clk_i);
        @(negedge clk_i);
        check("frozen_code", code_o.valid, 0);
        check("frozen_out", outputs_o, cam);
        @(posedge clk_i) en <= 1;
        @(posedge clk_i) cfg <= 0;
        @(negedge clk_i);
        check("thawed_code", code_o.num, ERR_CODE[E_CFG]);
        @(posedge clk_i) ack_i <= 1;
        @(posedge clk_i) ack_i <= 0;
        @(negedge clk_i);
        check("thawed_ack", code_o.valid, 0);
        @(negedge clk_i);
        check("thawed_out", outputs_o, cam);
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1;
        @(negedge clk_i);
        check("reset_code", code_o, 16'h0);
        @(negedge clk_i);
        check("idle_outputs", outputs_o, cam);
        for (int i = 0; i < $size(ks); i++)
            event_case(ks[i]);
        freeze_case();
        results();
    end
endmodule // cec_error_supervisor_tb
